// File: include/cdg_pkg.sv
// constants, register images and gain arithmetic for the codec gain path
package cdg_pkg;
  localparam int APB_AW = 8;
  // register indices; byte address is four times the index
  localparam logic [5:0] REG_RX_IDX   = 6'h05;
  localparam logic [5:0] REG_ADC_IDX  = 6'h06;
  localparam logic [5:0] REG_DAC_IDX  = 6'h07;
  localparam logic [5:0] REG_ATT_IDX  = 6'h09;
  localparam logic [5:0] REG_HPF_IDX  = 6'h0b;
  localparam logic [5:0] REG_STAT_IDX = 6'h0c;
  // writable bits of each 8-bit register
  localparam logic [7:0] RX_WMASK  = 8'h7f;
  localparam logic [7:0] ADC_WMASK = 8'h9f;
  localparam logic [7:0] DAC_WMASK = 8'hff;
  localparam logic [7:0] ATT_WMASK = 8'h0f;
  // values after reset; gain code 8 is 0 dB
  localparam logic [7:0] RX_RST  = 8'h00;
  localparam logic [7:0] ADC_RST = 8'h08;
  localparam logic [7:0] DAC_RST = 8'h08;
  localparam logic [7:0] ATT_RST = 8'h00;
  localparam logic [4:0] GAIN_UNITY = 5'h08;
  localparam logic [1:0] LINE_GAIN_MAX = 2'h2;
  // zero-cross fallback, in frames
  localparam int FALLBACK_FRAMES = 256;
  localparam logic [7:0] FALLBACK_LAST = 8'(FALLBACK_FRAMES - 1);
  localparam int GAIN_FRAC = 13;
  localparam logic signed [32:0] SMP_MAX = 33'sh0_0000_7fff;
  localparam logic signed [32:0] SMP_MIN = 33'sh1_ffff_8000;

  typedef logic signed [15:0] cdg_smp_t;
  typedef struct packed {
    logic       rsv;
    logic       handset_in_mute;
    logic       mic_mute;
    logic       line_input_mute;
    logic [1:0] line_in_gain;
    logic [1:0] mic_gain;
  } cdg_rx_s;
  typedef struct packed {
    logic       line_out_mute;
    logic [1:0] rsv;
    logic [4:0] gain;
  } cdg_adc_s;
  typedef struct packed {
    logic       handset_out_mute;
    logic       speaker_left_mute;
    logic       speaker_right_mute;
    logic [4:0] gain;
  } cdg_dac_s;
  typedef struct packed {
    logic [3:0] rsv;
    logic [1:0] line_atten;
    logic [1:0] spk_atten;
  } cdg_att_s;
  typedef struct packed {
    cdg_rx_s  rx;
    cdg_adc_s adc;
    cdg_dac_s dac;
    cdg_att_s att;
    logic     highpass_disable;
  } cdg_ana_s;

  // linear factor in 3.13 form; code 0 is +12 dB, each step -1.5 dB
  function automatic logic [15:0] gain_lin(logic [4:0] code);
    logic [15:0] t [32];
    t = '{16'h7f65, 16'h6b30, 16'h5a30, 16'h4be2, 16'h3fd9, 16'h35b9, 16'h2d34, 16'h2608,
          16'h2000, 16'h1aed, 16'h16a8, 16'h1310, 16'h100a, 16'h0d7f, 16'h0b5b, 16'h098e,
          16'h080a, 16'h06c3, 16'h05b1, 16'h04ca, 16'h0407, 16'h0364, 16'h02da, 16'h0266,
          16'h0205, 16'h01b3, 16'h016e, 16'h0134, 16'h0103, 16'h00da, 16'h00b7, 16'h009a};
    return t[code];
  endfunction : gain_lin

  // scale one sample, saturating to the 16-bit range
  function automatic cdg_smp_t gain_apply(cdg_smp_t x, logic [4:0] code);
    logic signed [32:0] p;
    p = x * $signed({1'b0, gain_lin(code)});
    p = p >>> GAIN_FRAC;
    if (p > SMP_MAX)
      return 16'sh7fff;
    if (p < SMP_MIN)
      return 16'sh8000;
    return p[15:0];
  endfunction : gain_apply

  function automatic logic [APB_AW-1:0] reg_byte(logic [5:0] idx);
    return {idx, 2'b00};
  endfunction : reg_byte
endpackage : cdg_pkg

// File: rtl/cdg_gain_mute.sv
// record and playback digital gain with zero-cross level update, apb control
`timescale 1ns/1ps
// Overview of operation
// - samples are 16-bit two's complement
// - record gain +12 to -34.5 dB, 1.5 dB steps
// - playback gain same range and step
// - new level applied only at zero crossing
// - apply anyway after 256 frames
// - each analog input has its own mute
// - each analog output mutes independently
// - line output mute bit in register 6
// - speaker left/right mute bits in register 7
// - analog output attenuation from register 9
// - pre-amp gain selects in register 5
// - mic 0-30 dB, line 0-20 dB gain
// - highpass disable extends passband to DC
// - one frame equals one sample
module cdg_gain_mute
  import cdg_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // sample inputs, index 0 record, 1 playback
  input  wire logic [1:0]        s_valid,
  output logic [1:0]             s_ready,
  input  wire cdg_smp_t [1:0]    s_data,
  // sample outputs after gain
  output logic [1:0]             m_valid,
  input  wire logic [1:0]        m_ready,
  output cdg_smp_t [1:0]         m_data,
  // analog path controls
  output cdg_ana_s               ana
);

  logic [1:0]       pend_q;
  logic [1:0][7:0]  cnt_q;
  logic [1:0][4:0]  gain_q;
  logic [1:0]       prev_q;
  logic [1:0]       full_q;
  cdg_smp_t [1:0]   tail_q;

  // address decode
  wire hit_rx   = paddr == reg_byte(REG_RX_IDX);
  wire hit_adc  = paddr == reg_byte(REG_ADC_IDX);
  wire hit_dac  = paddr == reg_byte(REG_DAC_IDX);
  wire hit_att  = paddr == reg_byte(REG_ATT_IDX);
  wire hit_hpf  = paddr == reg_byte(REG_HPF_IDX);
  wire hit_stat = paddr == reg_byte(REG_STAT_IDX);
  wire mapped   = hit_rx | hit_adc | hit_dac | hit_att | hit_hpf | hit_stat;
  wire wr       = psel & penable & pready & pwrite;

  // write images with reserved bits forced low
  wire cdg_rx_s  rx_raw = cdg_rx_s'(pwdata[7:0] & RX_WMASK);
  wire cdg_adc_s adc_w  = cdg_adc_s'(pwdata[7:0] & ADC_WMASK);
  wire cdg_dac_s dac_w  = cdg_dac_s'(pwdata[7:0] & DAC_WMASK);
  wire cdg_att_s att_w  = cdg_att_s'(pwdata[7:0] & ATT_WMASK);
  // line gain clamp
  // the line pre-amp has no 30 dB step, so code 3 falls back to 20 dB
  wire [1:0] line_g = (rx_raw.line_in_gain > LINE_GAIN_MAX) ? LINE_GAIN_MAX
                                                             : rx_raw.line_in_gain;
  wire cdg_rx_s  rx_w   = {rx_raw[7:4], line_g, rx_raw.mic_gain};

  // record and playback request decode
  // a gain request is any write to the volume register, even same value
  wire [1:0] wr_gain = {wr & hit_dac, wr & hit_adc};
  wire [1:0][4:0] tgt = {ana.dac.gain, ana.adc.gain};

  // read data
  wire [31:0] stat  = {20'h0, pend_q, gain_q[1], gain_q[0]};
  wire [31:0] rdata = hit_rx  ? {24'h0, ana.rx}  :
                      hit_adc ? {24'h0, ana.adc} :
                      hit_dac ? {24'h0, ana.dac} :
                      hit_att ? {24'h0, ana.att} :
                      hit_hpf ? {31'h0, ana.highpass_disable} :
                      hit_stat ? stat : 32'h0;

  // apb answer: ready in the first access cycle, data caught in setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      prdata  <= rdata;
      pslverr <= psel & ~penable & ~mapped;
    end
  end

  // control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ana.rx  <= cdg_rx_s'(RX_RST);
      ana.adc <= cdg_adc_s'(ADC_RST);
      ana.dac <= cdg_dac_s'(DAC_RST);
      ana.att <= cdg_att_s'(ATT_RST);
      ana.highpass_disable <= 1'b0;
    end
    else
    begin
      if (wr && hit_rx)
        ana.rx <= rx_w;
      if (wr && hit_adc)
        ana.adc <= adc_w;
      if (wr && hit_dac)
        ana.dac <= dac_w;
      if (wr && hit_att)
        ana.att <= att_w;
      if (wr && hit_hpf)
        ana.highpass_disable <= pwdata[0];
    end
  end

  wire [1:0]            take;
  wire [1:0]            zc;
  wire [1:0]            due;
  wire [1:0][4:0]       eff;
  wire cdg_smp_t [1:0]  res;
  wire [1:0]            pop;
  wire [1:0]            full_d;

  // per-path gain stage and two-entry output buffer
  for (genvar i = 0; i < 2; i++)
  begin : g_path
    assign take[i] = s_valid[i] & s_ready[i];
    // sign change detect
    // an exact zero sample also counts, it is silence either way
    assign zc[i]  = (s_data[i] == 16'sh0000) | (s_data[i][15] != prev_q[i]);
    assign due[i] = pend_q[i] & (zc[i] | (cnt_q[i] == FALLBACK_LAST));
    assign eff[i] = due[i] ? tgt[i] : gain_q[i];
    assign res[i] = gain_apply(s_data[i], eff[i]);
    assign pop[i] = m_valid[i] & m_ready[i];
    // one word per frame
    // no entry free after a push onto a held head
    assign full_d[i] = full_q[i] ? ~pop[i] : (take[i] & ~pop[i] & m_valid[i]);

    unity_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
      take[i] && eff[i] == GAIN_UNITY |-> res[i] == s_data[i])
      else $error("unity gain altered sample");
    gain_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(gain_q[i]) |-> $past(take[i] && due[i]))
      else $error("gain changed without crossing or timeout");
    zero_cross_a: assert property (@(posedge pclk) disable iff (!presetn)
      take[i] && pend_q[i] && zc[i] && !wr_gain[i] |=> !pend_q[i] ##0
      gain_q[i] == $past(tgt[i]))
      else $error("crossing did not apply level");
    fallback_a: assert property (@(posedge pclk) disable iff (!presetn)
      take[i] && pend_q[i] && cnt_q[i] == FALLBACK_LAST && !wr_gain[i]
      |=> gain_q[i] == $past(tgt[i]) && !pend_q[i])
      else $error("fallback level not applied");
    restart_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_gain[i] |=> pend_q[i] && cnt_q[i] == 8'h00)
      else $error("request did not restart count");
    buf_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      m_valid[i] && !m_ready[i] |=> m_valid[i] && $stable(m_data[i]))
      else $error("stalled output word lost");
    // an empty buffer must show the accepted word on the next cycle
    out_valid_a: assert property (@(posedge pclk) disable iff (!presetn)
      take[i] && !m_valid[i] |=> m_valid[i] && m_data[i] == $past(res[i]))
      else $error("accepted sample not presented");
    no_overrun_a: assert property (@(posedge pclk) disable iff (!presetn)
      full_q[i] && !pop[i] |=> !s_ready[i])
      else $error("full buffer still accepting");
  end

  // gain state and buffer registers for both paths
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_q  <= 2'h0;
      cnt_q   <= '0;
      gain_q  <= {GAIN_UNITY, GAIN_UNITY};
      prev_q  <= 2'h0;
      full_q  <= 2'h0;
      tail_q  <= '0;
      m_valid <= 2'h0;
      m_data  <= '0;
      s_ready <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        // request tracking, fallback count
        // a fresh request wins over an apply in the same cycle
        if (wr_gain[i])
        begin
          pend_q[i] <= 1'b1;
          cnt_q[i]  <= 8'h00;
        end
        else if (take[i] && due[i])
          pend_q[i] <= 1'b0;
        else if (take[i] && pend_q[i])
          cnt_q[i] <= cnt_q[i] + 8'h01;
        if (take[i])
          prev_q[i] <= s_data[i][15];
        if (take[i] && due[i])
          gain_q[i] <= tgt[i];
        if (take[i] && (!m_valid[i] || (pop[i] && !full_q[i])))
          m_data[i] <= res[i];
        else if (pop[i] && full_q[i])
          m_data[i] <= tail_q[i];
        if (take[i] && (full_q[i] || (m_valid[i] && !pop[i])))
          tail_q[i] <= res[i];
        m_valid[i] <= take[i] | full_q[i] | (m_valid[i] & ~pop[i]);
        full_q[i]  <= full_d[i];
        s_ready[i] <= ~full_d[i];
      end
    end
  end

  line_mute_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_adc |=> ana.adc.line_out_mute == $past(adc_w.line_out_mute))
    else $error("line output mute not stored");
  spk_mute_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_dac |=> ana.dac.speaker_left_mute == $past(dac_w.speaker_left_mute) &&
    ana.dac.speaker_right_mute == $past(dac_w.speaker_right_mute))
    else $error("speaker mutes not stored");
  line_gain_a: assert property (@(posedge pclk) disable iff (!presetn)
    ana.rx.line_in_gain <= LINE_GAIN_MAX)
    else $error("line pre-amp gain out of range");
  hpf_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_hpf |=> ana.highpass_disable == $past(pwdata[0]))
    else $error("highpass disable not stored");

  // register images checked against the raw write data, not the masks
  in_mute_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_rx |=> ana.rx.mic_mute == $past(pwdata[5]) &&
    ana.rx.line_input_mute == $past(pwdata[4]) &&
    ana.rx.handset_in_mute == $past(pwdata[6]))
    else $error("input mutes not stored");
  out_mute_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_dac |=> ana.dac.handset_out_mute == $past(pwdata[7]) &&
    ana.adc == $past(ana.adc))
    else $error("output mutes not independent");
  atten_store_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_att |=> ana.att.line_atten == $past(pwdata[3:2]) &&
    ana.att.spk_atten == $past(pwdata[1:0]) && ana.att.rsv == 4'h0)
    else $error("attenuation select not stored");
  mic_gain_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_rx |=> ana.rx.mic_gain == $past(pwdata[1:0]))
    else $error("mic pre-amp gain not stored");

  // gain requests land in the volume images
  rec_code_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_adc |=> ana.adc.gain == $past(pwdata[4:0]))
    else $error("record gain code not stored");
  ply_code_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_dac |=> ana.dac.gain == $past(pwdata[4:0]))
    else $error("playback gain code not stored");

  // the host never waits more than one access cycle
  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready && pslverr == !$past(mapped))
    else $error("register access not answered");

endmodule : cdg_gain_mute

// File: verif/cdg_dsp_sink.sv
// behavioural dsp-side sink taking gained samples, with stall control
`timescale 1ns/1ps
module cdg_dsp_sink
  import cdg_pkg::*;
(
  // clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // stall request per path, 1 holds ready low
  input  wire logic [1:0]     stall,
  // sample stream from the block
  input  wire logic [1:0]     m_valid,
  output logic [1:0]          m_ready,
  input  wire cdg_smp_t [1:0] m_data
);
  cdg_smp_t rec_q [$];
  cdg_smp_t ply_q [$];
  // ready follows stall with no latency, so stalls land at any cycle
  assign m_ready = ~stall;
  always @(posedge pclk)
  begin
    if (presetn && m_valid[0] && m_ready[0])
      rec_q.push_back(m_data[0]);
    if (presetn && m_valid[1] && m_ready[1])
      ply_q.push_back(m_data[1]);
  end
endmodule : cdg_dsp_sink

// File: verif/cdg_gain_mute_tb.sv
// self-checking bench for the codec gain and mute path
`timescale 1ns/1ps
module cdg_gain_mute_tb;
  import cdg_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [1:0]        s_valid, s_ready, m_valid, m_ready, stall;
  cdg_smp_t [1:0]    s_data, m_data;
  cdg_ana_s          ana;
  int                miscompares, cmp_count, cycles;

  cdg_gain_mute cdg_gain_mute_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .s_valid(s_valid), .s_ready(s_ready),
    .s_data(s_data), .m_valid(m_valid), .m_ready(m_ready), .m_data(m_data), .ana(ana));
  cdg_dsp_sink cdg_dsp_sink_i (.pclk(pclk), .presetn(presetn), .stall(stall),
    .m_valid(m_valid), .m_ready(m_ready), .m_data(m_data));

  // free-running 100 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // hang guard, far above the thousand-odd cycles the run needs
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // apb transfer; answer taken at the edge where pready is high
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // let the written image settle before callers look at it
    @(negedge pclk);
  endtask : apb

  // bit 32 of the expected value is the error response
  task automatic rdchk(input logic [5:0] idx, input logic [32:0] exp);
    apb(1'b0, idx, 32'h0);
    chk({7'h0, er, rd}, {7'h0, exp});
  endtask : rdchk

  // data line shows the inverse once released, never a stale word
  task send(input int p, input cdg_smp_t x);
    @(posedge pclk);
    s_valid[p] <= 1'b1;
    s_data[p]  <= x;
    @(posedge pclk);
    while (s_ready[p] !== 1'b1)
      @(posedge pclk);
    s_valid[p] <= 1'b0;
    s_data[p]  <= ~x;
  endtask : send

  task automatic pop(input int p, input cdg_smp_t e);
    cdg_smp_t got;
    @(negedge pclk);
    while ((p == 0 ? cdg_dsp_sink_i.rec_q.size() : cdg_dsp_sink_i.ply_q.size()) == 0)
      @(negedge pclk);
    got = (p == 0) ? cdg_dsp_sink_i.rec_q.pop_front() : cdg_dsp_sink_i.ply_q.pop_front();
    chk(40'(got), 40'(e));
  endtask : pop

  task automatic xfer(input int p, input cdg_smp_t x, input cdg_smp_t e);
    send(p, x);
    pop(p, e);
  endtask : xfer

  task automatic t_reset();
    @(negedge pclk);
    chk(40'(ana), 40'({RX_RST, ADC_RST, DAC_RST, ATT_RST, 1'b0}));
    rdchk(REG_ADC_IDX, 32'(ADC_RST));
    rdchk(REG_DAC_IDX, 32'(DAC_RST));
    rdchk(REG_ATT_IDX, 32'(ATT_RST));
    apb(1'b1, 6'h0f, 32'h55);
    rdchk(6'h0f, {1'b1, 32'h0});
    chk(40'(er), 40'h1);
  endtask : t_reset

  task automatic t_regs();
    apb(1'b1, REG_RX_IDX, 32'hff);
    rdchk(REG_RX_IDX, 32'h7b);
    chk({ana.rx.mic_gain, ana.rx.line_in_gain}, 40'he);
    apb(1'b1, REG_RX_IDX, 32'h10);
    chk({ana.rx.handset_in_mute, ana.rx.mic_mute, ana.rx.line_input_mute}, 40'h1);
    apb(1'b1, REG_RX_IDX, 32'h60);
    chk({ana.rx.handset_in_mute, ana.rx.mic_mute, ana.rx.line_input_mute}, 40'h6);
    apb(1'b1, REG_ADC_IDX, 32'hff);
    rdchk(REG_ADC_IDX, 32'h9f);
    chk(40'(ana.adc.line_out_mute), 40'h1);
    apb(1'b1, REG_DAC_IDX, 32'h40);
    chk({ana.dac.handset_out_mute, ana.dac.speaker_left_mute,
         ana.dac.speaker_right_mute}, 40'h2);
    apb(1'b1, REG_DAC_IDX, 32'ha0);
    chk({ana.dac.handset_out_mute, ana.dac.speaker_left_mute,
         ana.dac.speaker_right_mute}, 40'h5);
    apb(1'b1, REG_ATT_IDX, 32'hf6);
    rdchk(REG_ATT_IDX, 32'h06);
    chk({ana.att.line_atten, ana.att.spk_atten}, 40'h6);
    apb(1'b1, REG_HPF_IDX, 32'h1);
    chk(40'(ana.highpass_disable), 40'h1);
    apb(1'b1, REG_HPF_IDX, 32'h0);
    chk(40'(ana.highpass_disable), 40'h0);
  endtask : t_regs

  // record path: new level waits for the sign change
  task automatic t_cross();
    apb(1'b1, REG_ADC_IDX, 32'h00);
    rdchk(REG_STAT_IDX, 32'hd08);
    xfer(0, 16'sd100, 16'sd100);
    xfer(0, 16'sd100, 16'sd100);
    xfer(0, -16'sd1000, 16'shf072);
    rdchk(REG_STAT_IDX, 32'h900);
    xfer(0, -16'sd1000, 16'shf072);
  endtask : t_cross

  // playback path: fallback after 256 frames, restarted by a rewrite
  task automatic t_fallback();
    apb(1'b1, REG_DAC_IDX, 32'h1f);
    repeat (100) xfer(1, 16'sd1000, 16'sd1000);
    apb(1'b1, REG_DAC_IDX, 32'h1f);
    repeat (255) xfer(1, 16'sd1000, 16'sd1000);
    rdchk(REG_STAT_IDX, 32'h900);
    xfer(1, 16'sd1000, 16'sh0012);
    rdchk(REG_STAT_IDX, 32'h3e0);
  endtask : t_fallback

  // stalled sink: two words held, ready dropped, none lost
  task automatic t_stall();
    stall <= 2'b01;
    send(0, -16'sd1000);
    send(0, -16'sd1000);
    repeat (3) @(negedge pclk);
    chk(40'(s_ready[0]), 40'h0);
    stall <= 2'b00;
    pop(0, 16'shf072);
    pop(0, 16'shf072);
    chk(40'(s_ready[0]), 40'h1);
  endtask : t_stall

  // reset for five cycles, then the scenarios in turn
  initial
  begin
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = '0;
    pwdata      = '0;
    s_valid     = 2'b00;
    s_data      = '0;
    stall       = 2'b00;
    miscompares = 0;
    cmp_count   = 0;
    cycles      = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_cross();
    t_fallback();
    t_stall();
    report_and_stop();
  end
endmodule : cdg_gain_mute_tb
